// ==== inc/t2cc_defines.svh ====
// Purpose: Register map, field positions and counts for the 16-bit timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by bare name from every design file
`ifndef T2CC_DEFINES_SVH
`define T2CC_DEFINES_SVH

// Register byte offsets
`define T2CC_OFF_CTRL    8'h00
`define T2CC_OFF_MODE    8'h04
`define T2CC_OFF_COUNT   8'h08
`define T2CC_OFF_CAPTURE 8'h0C
`define T2CC_OFF_STATUS  8'h10
`define T2CC_OFF_MASK    8'h14

// Control register fields
`define T2CC_CTRL_CAPSEL 0
`define T2CC_CTRL_SRC    1
`define T2CC_CTRL_RUN    2
`define T2CC_CTRL_EXTEN  3
`define T2CC_CTRL_TXSEL  4
`define T2CC_CTRL_RXSEL  5

// Mode register fields
`define T2CC_MODE_DOWN   0
`define T2CC_MODE_CLKOUT 1
`define T2CC_MODE_TWELVE 2
`define T2CC_MODE_PINVAL 3
`define T2CC_MODE_PINOE  4

// Status and mask fields
`define T2CC_ST_OVF      0
`define T2CC_ST_EXT      1

// Oscillator clocks per count step
`define T2CC_DIV_6CLK    4'h6
`define T2CC_DIV_12CLK   4'hC
`define T2CC_DIV_FAST6   4'h1
`define T2CC_DIV_FAST12  4'h2

// Reset and limit values
`define T2CC_COUNT_MAX   16'hFFFF
`define T2CC_RST16       16'h0000
`define T2CC_PIN_IDLE    1'b1

`endif

// ==== inc/t2cc_pkg.sv ====
// Purpose: Shared types for the 16-bit timer
// Assumes: Used by scoped name only
// Notes:   Operating mode decoded from control bits
package t2cc_pkg;
    typedef enum logic [1:0] {
        T2CC_CAPTURE,
        T2CC_RELOAD,
        T2CC_BAUD
    } t2cc_mode_t;
endpackage

// ==== rtl/t2cc_pin_sync.sv ====
// Purpose: Three-stage pin synchroniser with falling-edge pulse
// Assumes: Pin is asynchronous to clk
// Notes:   Level changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "t2cc_defines.svh"
module t2cc_pin_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;
    logic next_fall;

    // Stage one feeds stage two only
    always_comb
    begin
        next_level = level;
        next_fall  = 1'b0;
        if (s2 == s3)
        begin
            next_level = s3;
            next_fall  = level & ~s3; // One pulse per settled falling edge
        end
    end

    // Idle high keeps reset from looking like an edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1    <= `T2CC_PIN_IDLE;
            s2    <= `T2CC_PIN_IDLE;
            s3    <= `T2CC_PIN_IDLE;
            level <= `T2CC_PIN_IDLE;
            fall  <= 1'b0;
        end
        else
        begin
            s1    <= pinIn;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
            fall  <= next_fall;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/t2cc_prescaler.sv ====
// Purpose: Divides the oscillator into count steps
// Assumes: divide is at least one
// Notes:   Restarts whenever run drops
`timescale 1ns/100ps
`default_nettype none
`include "t2cc_defines.svh"
module t2cc_prescaler (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [3:0] divide,
    output logic            tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       next_tick;

    // One tick every divide clocks
    always_comb
    begin
        next_cnt  = 4'h0;
        next_tick = 1'b0;
        if (run)
        begin
            if (4'(cnt + 4'h1) >= divide)
                next_tick = 1'b1;
            else
                next_cnt = 4'(cnt + 4'h1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt  <= 4'h0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/t2cc_timer.sv ====
// Purpose: 16-bit timer/counter with capture, reload, baud and clock-out
// Assumes: clk is the oscillator; APB slave with one wait state
// Notes:   Flags are write-one-to-clear; hardware set wins
//
// Summary of operation
// - 16-bit count of prescaled clock or shared-pin falling edges, chosen by source bit.
// - Capture, auto-reload up/down and baud generation modes chosen by control bits.
// - Capture mode without trigger enable: plain counter, overflow sets overflow flag.
// - Overflow flag drives the interrupt when its enable bit is set.
// - Trigger falling edge with enable copies count bytes into capture bytes.
// - Capture sets external flag; same interrupt; both flags readable.
// - Capture mode never reloads; counting continues across capture.
// - Timer steps every 6 or 12 clocks, or every 1 or 2 for baud or clock-out; counter steps on pin edges.
// - Shared pin is plain I/O, count input, or square-wave output.
// - Clock-out frequency is osc over 2n times (65536 minus capture value).
// - Capture bytes form one unsigned 16-bit value, high byte on top.
// - Clock-out roll-overs raise no interrupt request.
// - Baud and clock-out may run together from one roll-over stream.
// - Overflow flag stays clear while serial clock selects route this timer.
`timescale 1ns/100ps
`default_nettype none
`include "t2cc_defines.svh"
module t2cc_timer (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        triggerPin,
    input  wire logic        sharedPinIn,
    output logic             sharedPinOut,
    output logic             sharedPinOe,
    output logic             serialClockPulse,
    output logic             irq
);
    // Control bits
    logic        captureSelect;
    logic        countSourceSelect;
    logic        runControl;
    logic        externalTriggerEnable;
    logic        serialTxClockSelect;
    logic        serialRxClockSelect;
    // Mode bits
    logic        downCountEnable;
    logic        clockOutputEnable;
    logic        twelveClockMode;
    logic        pinValue;
    logic        pinDriveEnable;
    // Datapath
    logic [15:0] count;
    logic [15:0] capture;
    logic [1:0]  status;
    logic [1:0]  mask;
    // Next values
    logic [5:0]  next_ctrl;
    logic [4:0]  next_mode;
    logic [15:0] next_count;
    logic [15:0] next_capture;
    logic [1:0]  next_status;
    logic [1:0]  next_mask;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_pinOut;
    logic        next_pinOe;
    logic        next_serial;
    logic        next_irq;
    // Internal
    t2cc_pkg::t2cc_mode_t mode;
    logic        trigLevel;
    logic        trigFall;
    logic        pinLevel;
    logic        pinFall;
    logic        preTick;
    logic        fastStep;
    logic [3:0]  divide;
    logic        incTick;
    logic        roll;
    logic        ovfEvent;
    logic        extEvent;
    logic        mapped;
    logic        wrDone;

    // True when the bus address selects the given register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    t2cc_pin_sync u_trig (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (triggerPin),
        .level   (trigLevel),
        .fall    (trigFall)
    );

    t2cc_pin_sync u_pin (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (sharedPinIn),
        .level   (pinLevel),
        .fall    (pinFall)
    );

    // Baud and clock-out step at osc or osc/2 so a toggle per roll-over
    // gives osc / (2 * n * (65536 - capture))
    always_comb
    begin
        fastStep = serialTxClockSelect | serialRxClockSelect | clockOutputEnable;
        if (fastStep)
            divide = twelveClockMode ? `T2CC_DIV_FAST12 : `T2CC_DIV_FAST6;
        else
            divide = twelveClockMode ? `T2CC_DIV_12CLK : `T2CC_DIV_6CLK;
    end

    t2cc_prescaler u_pre (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (runControl),
        .divide  (divide),
        .tick    (preTick)
    );

    // Mode decode: serial selects win, clock-out needs the reload path
    always_comb
    begin
        if (serialTxClockSelect | serialRxClockSelect)
            mode = t2cc_pkg::T2CC_BAUD;
        else if (captureSelect & ~clockOutputEnable)
            mode = t2cc_pkg::T2CC_CAPTURE;
        else
            mode = t2cc_pkg::T2CC_RELOAD;
    end

    // Step source: prescaled clock or synchronised pin edges
    always_comb
    begin
        incTick = runControl & (countSourceSelect ? pinFall : preTick);
    end

    // APB decode; writes land at the edge that samples pready high
    always_comb
    begin
        mapped = hit(paddr, `T2CC_OFF_CTRL) | hit(paddr, `T2CC_OFF_MODE)
               | hit(paddr, `T2CC_OFF_COUNT) | hit(paddr, `T2CC_OFF_CAPTURE)
               | hit(paddr, `T2CC_OFF_STATUS) | hit(paddr, `T2CC_OFF_MASK);
        wrDone = psel & penable & pready & pwrite & mapped;
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped;
        next_prdata  = 32'h0000_0000;
        if (psel & penable & ~pready & ~pwrite)
        begin
            case (paddr)
                `T2CC_OFF_CTRL:
                    next_prdata[5:0] = {serialRxClockSelect, serialTxClockSelect,
                                        externalTriggerEnable, runControl,
                                        countSourceSelect, captureSelect};
                `T2CC_OFF_MODE:
                    next_prdata[4:0] = {pinDriveEnable, pinValue, twelveClockMode,
                                        clockOutputEnable, downCountEnable};
                `T2CC_OFF_COUNT:   next_prdata[15:0] = count;
                `T2CC_OFF_CAPTURE: next_prdata[15:0] = capture;
                `T2CC_OFF_STATUS:  next_prdata[1:0] = status;
                `T2CC_OFF_MASK:    next_prdata[1:0] = mask;
                default:           next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Control and mode registers
    always_comb
    begin
        next_ctrl = {serialRxClockSelect, serialTxClockSelect, externalTriggerEnable,
                     runControl, countSourceSelect, captureSelect};
        next_mode = {pinDriveEnable, pinValue, twelveClockMode,
                     clockOutputEnable, downCountEnable};
        next_mask = mask;
        if (wrDone & hit(paddr, `T2CC_OFF_CTRL))
            next_ctrl = pwdata[5:0];
        if (wrDone & hit(paddr, `T2CC_OFF_MODE))
            next_mode = pwdata[4:0];
        if (wrDone & hit(paddr, `T2CC_OFF_MASK))
            next_mask = pwdata[1:0];
    end

    // Count and capture datapath
    always_comb
    begin
        next_count   = count;
        next_capture = capture;
        roll         = 1'b0;
        extEvent     = 1'b0;
        if (wrDone & hit(paddr, `T2CC_OFF_CAPTURE))
            next_capture = pwdata[15:0];
        case (mode)
            t2cc_pkg::T2CC_CAPTURE:
            begin
                if (incTick)
                begin
                    next_count = 16'(count + 16'h0001); // Never reloads
                    roll = (count == `T2CC_COUNT_MAX);
                end
                if (externalTriggerEnable & trigFall)
                begin
                    next_capture = count; // High and low bytes together
                    extEvent = 1'b1;
                end
            end
            t2cc_pkg::T2CC_RELOAD:
            begin
                if (incTick)
                begin
                    if (downCountEnable & ~trigLevel)
                    begin
                        // Down count underflows at the capture value
                        roll = (count == capture);
                        next_count = roll ? `T2CC_COUNT_MAX : 16'(count - 16'h0001);
                    end
                    else
                    begin
                        roll = (count == `T2CC_COUNT_MAX);
                        next_count = roll ? capture : 16'(count + 16'h0001);
                    end
                end
                // Up/down mode uses the trigger as direction, not as an event
                if (externalTriggerEnable & ~downCountEnable & trigFall)
                begin
                    next_count = capture;
                    extEvent = 1'b1;
                end
            end
            t2cc_pkg::T2CC_BAUD:
            begin
                if (incTick)
                begin
                    roll = (count == `T2CC_COUNT_MAX);
                    next_count = roll ? capture : 16'(count + 16'h0001);
                end
                if (externalTriggerEnable & trigFall)
                    extEvent = 1'b1;
            end
            default:
            begin
                next_count = count;
            end
        endcase
        // Software write to the count wins over a step in the same cycle
        if (wrDone & hit(paddr, `T2CC_OFF_COUNT))
            next_count = pwdata[15:0];
    end

    // Overflow flag is held off when the roll-over feeds serial or clock-out
    always_comb
    begin
        ovfEvent = roll & ~serialTxClockSelect & ~serialRxClockSelect
                 & ~clockOutputEnable;
        next_status = status;
        if (wrDone & hit(paddr, `T2CC_OFF_STATUS))
            next_status = status & ~pwdata[1:0]; // Only software clears
        next_status[`T2CC_ST_OVF] = next_status[`T2CC_ST_OVF] | ovfEvent;
        next_status[`T2CC_ST_EXT] = next_status[`T2CC_ST_EXT] | extEvent;
        next_irq = |(next_status & mask);
    end

    // Shared pin: square wave when enabled, otherwise plain output or input
    always_comb
    begin
        next_serial = roll & (serialTxClockSelect | serialRxClockSelect);
        if (clockOutputEnable)
        begin
            next_pinOe  = 1'b1;
            next_pinOut = roll ? ~sharedPinOut : sharedPinOut;
        end
        else
        begin
            // Input role when not driven; counter use needs drive off
            next_pinOe  = pinDriveEnable;
            next_pinOut = pinValue;
        end
    end

    // All state registers; outputs come straight from here
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {serialRxClockSelect, serialTxClockSelect, externalTriggerEnable,
             runControl, countSourceSelect, captureSelect} <= 6'h00;
            {pinDriveEnable, pinValue, twelveClockMode,
             clockOutputEnable, downCountEnable} <= 5'h00;
            count            <= `T2CC_RST16;
            capture          <= `T2CC_RST16;
            status           <= 2'h0;
            mask             <= 2'h0;
            prdata           <= 32'h0000_0000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            sharedPinOut     <= 1'b0;
            sharedPinOe      <= 1'b0;
            serialClockPulse <= 1'b0;
            irq              <= 1'b0;
        end
        else
        begin
            {serialRxClockSelect, serialTxClockSelect, externalTriggerEnable,
             runControl, countSourceSelect, captureSelect} <= next_ctrl;
            {pinDriveEnable, pinValue, twelveClockMode,
             clockOutputEnable, downCountEnable} <= next_mode;
            count            <= next_count;
            capture          <= next_capture;
            status           <= next_status;
            mask             <= next_mask;
            prdata           <= next_prdata;
            pready           <= next_pready;
            pslverr          <= next_pslverr;
            sharedPinOut     <= next_pinOut;
            sharedPinOe      <= next_pinOe;
            serialClockPulse <= next_serial;
            irq              <= next_irq;
        end
    end

    // pinLevel is kept for software-visible pin reads in a later revision
    logic unusedPinLevel;
    assign unusedPinLevel = pinLevel;
endmodule
`default_nettype wire

// ==== verification/t2cc_timer_checker.sv ====
// Purpose: Port-level properties of the 16-bit timer
// Assumes: Bound to the top module; one clock domain
// Notes:   Flags are not visible here, so the interrupt line stands in for them
`timescale 1ns/100ps
`default_nettype none
`include "t2cc_defines.svh"
module t2cc_timer_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sharedPinOe,
    input wire logic        serialClockPulse,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Steps of one bus transfer before the answer
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Only a status write (one edge back) or a mask write (two edges back) drops the line
    sequence s_flag_write;
        pready && pwrite && (paddr == `T2CC_OFF_STATUS || paddr == `T2CC_OFF_MASK);
    endsequence

    property p_one_wait;
        s_setup ##1 s_wait |=> pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable && $past(psel && penable);
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_unmapped;
        pready && paddr > `T2CC_OFF_MASK |-> pslverr && prdata == 32'h0;
    endproperty
    property p_err_mapped;
        pready && paddr <= `T2CC_OFF_MASK && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    property p_data_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_irq_clear;
        $fell(irq) |-> $past(pready && pwrite && paddr == `T2CC_OFF_STATUS)
                    || $past(pready && pwrite && paddr == `T2CC_OFF_MASK, 2);
    endproperty
    property p_quiet_after_reset;
        $fell(sys_rst) |-> !irq && !sharedPinOe && !serialClockPulse && !pready;
    endproperty

    a_one_wait: assert property (p_one_wait) else $error("pready not in second access cycle");
    a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    a_data_idle: assert property (p_data_idle) else $error("read data outside answer");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without pready");
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt dropped by itself");
    a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("output busy after reset");
    c_flag_write: cover property (s_flag_write);
endmodule
`default_nettype wire

// ==== verification/t2cc_pin_model.sv ====
// Purpose: Pin-side model for trigger and shared count pin
// Assumes: Both pins idle high through pull-ups
// Notes:   Shared pin level resolves the design's drive against ours
`timescale 1ns/100ps
`default_nettype none
module t2cc_pin_model (
    input  wire logic clk,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      triggerPin,
    output logic      sharedPin
);
    logic drive;

    // Design drive wins while enabled, else our level over the pull-up
    assign sharedPin = pinOe ? pinOut : drive;
    initial
    begin
        triggerPin = 1'b1;
        drive      = 1'b1;
    end
    // Low phase held long enough to pass the synchroniser
    task automatic fall_trigger();
        @(posedge clk);
        triggerPin <= 1'b0;
        repeat (8) @(posedge clk);
        triggerPin <= 1'b1;
    endtask
    // Count pulses, eight clocks low and eight high
    task automatic count_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            drive <= 1'b0;
            repeat (8) @(posedge clk);
            drive <= 1'b1;
            repeat (7) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== verification/test_timer2_capture_clockout.sv ====
// Purpose: Self-checking bench for the timer with capture and clock-out
// Assumes: 25 MHz clock; bus answer awaited, never counted on
// Notes:   Pin events land some clocks late, so timed counts allow one step
`timescale 1ns/100ps
`default_nettype none
`include "t2cc_defines.svh"
module test_timer2_capture_clockout;
    localparam int LIMIT = 20000;
    logic        clk, sysRst, psel, penable, pwrite, pready, pslverr, er;
    logic        triggerPin, sharedPinIn, sharedPinOut, sharedPinOe, serialClockPulse, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          numErrors, comparisons, cycle, t0, tf, k, n, hp, pul;

    t2cc_timer u_dut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .triggerPin(triggerPin), .sharedPinIn(sharedPinIn), .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe), .serialClockPulse(serialClockPulse), .irq(irq));
    t2cc_pin_model u_pins (.clk(clk), .pinOut(sharedPinOut), .pinOe(sharedPinOe),
        .triggerPin(triggerPin), .sharedPin(sharedPinIn));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Timed values may sit one prescaler step either side
    task automatic near(input logic [31:0] got, input int exp, input string what);
        comparisons++;
        if ($isunknown(got) || got > 32'(exp + 1) || got + 32'h1 < 32'(exp))
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: %s got %h near %h", $time, what, got, exp);
        end
    endtask
    // One bus transfer; held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    // Clocks until the shared pin changes, with serial pulses seen meanwhile
    task automatic wait_edge(output int len, output int pulses);
        logic was;
        was    = sharedPinOut;
        len    = 0;
        pulses = 0;
        do
        begin
            @(posedge clk);
            len++;
            pulses += int'(serialClockPulse);
        end
        while (sharedPinOut === was);
    endtask

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Cycle count doubles as the hang guard
    always @(posedge clk)
    begin
        cycle <= cycle + 1;
        if (cycle == LIMIT)
        begin
            numErrors++;
            final_report();
        end
    end

    // Main sequence
    initial
    begin
        {sysRst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {numErrors, comparisons, cycle} = 0;
        n = $urandom(11495);
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        for (int a = 0; a <= 6; a++)
        begin
            apb(1'b0, 8'(a * 4), $urandom, rd, er);
            check(rd, 32'h0, "reset value");
            check({31'h0, er}, {31'h0, a == 6}, "error flag");
        end
        $display("test reset done");
        for (int tw = 0; tw < 2; tw++)
        begin
            wr(`T2CC_OFF_MODE, 32'(tw) << `T2CC_MODE_TWELVE);
            // Capture mode with the trigger disabled, so overflow below is a plain timer
            wr(`T2CC_OFF_CTRL, 32'h5);
            wr(`T2CC_OFF_COUNT, 32'h0);
            t0 = cycle;
            repeat (240) @(posedge clk);
            apb(1'b0, `T2CC_OFF_COUNT, 32'h0, rd, er);
            near(rd, (cycle - t0) / (tw ? 12 : 6), "timer rate");
        end
        wr(`T2CC_OFF_MASK, 32'h1);
        wr(`T2CC_OFF_COUNT, 32'hFFFD);
        repeat (60) @(posedge clk);
        apb(1'b0, `T2CC_OFF_STATUS, 32'h0, rd, er);
        check(rd, 32'h1, "overflow flag");
        check({31'h0, irq}, 32'h1, "overflow interrupt");
        wr(`T2CC_OFF_STATUS, 32'h1);
        apb(1'b0, `T2CC_OFF_STATUS, 32'h0, rd, er);
        check(rd, 32'h0, "flag cleared");
        $display("test timer done");
        wr(`T2CC_OFF_MODE, 32'h0);
        wr(`T2CC_OFF_MASK, 32'h3);
        wr(`T2CC_OFF_CTRL, 32'hD);
        wr(`T2CC_OFF_COUNT, 32'h1234);
        t0 = cycle;
        tf = cycle + 1;
        u_pins.fall_trigger();
        apb(1'b0, `T2CC_OFF_CAPTURE, 32'h0, rd, er);
        near(rd, 'h1234 + (tf + 4 - t0) / 6, "captured count");
        apb(1'b0, `T2CC_OFF_STATUS, 32'h0, rd, er);
        check(rd, 32'h2, "external flag");
        check({31'h0, irq}, 32'h1, "external interrupt");
        apb(1'b0, `T2CC_OFF_COUNT, 32'h0, rd, er);
        near(rd, 'h1234 + (cycle - t0) / 6, "count after capture");
        // Reload mode, stopped: a trigger edge loads the count from capture
        wr(`T2CC_OFF_CTRL, 32'h8);
        wr(`T2CC_OFF_CAPTURE, 32'h5A5A);
        u_pins.fall_trigger();
        apb(1'b0, `T2CC_OFF_COUNT, 32'h0, rd, er);
        check(rd, 32'h5A5A, "reload on trigger");
        wr(`T2CC_OFF_STATUS, 32'h3);
        $display("test capture done");
        wr(`T2CC_OFF_CTRL, 32'h6);
        wr(`T2CC_OFF_COUNT, 32'h0);
        n = $urandom_range(20, 1);
        u_pins.count_pulses(n);
        repeat (8) @(posedge clk);
        apb(1'b0, `T2CC_OFF_COUNT, 32'h0, rd, er);
        check(rd, 32'(n), "pin events");
        $display("test counter done");
        for (int tw = 0; tw < 2; tw++)
        begin
            k = $urandom_range(18, 3);
            wr(`T2CC_OFF_CAPTURE, 32'h10000 - 32'(k));
            wr(`T2CC_OFF_COUNT, 32'h10000 - 32'(k));
            // Second pass drops the serial select, so only clock-out holds the flag off
            wr(`T2CC_OFF_CTRL, tw ? 32'h4 : 32'h14);
            wr(`T2CC_OFF_MODE, 32'h12 | (32'(tw) << `T2CC_MODE_TWELVE));
            wr(`T2CC_OFF_STATUS, 32'h3);
            wait_edge(hp, pul);
            wait_edge(hp, pul);
            check(32'(hp), 32'(k * (tw + 1)), "half period");
            check(32'(pul), 32'(1 - tw), "serial pulses per half period");
            check({31'h0, sharedPinOe}, 32'h1, "clock pin driven");
            apb(1'b0, `T2CC_OFF_STATUS, 32'h0, rd, er);
            check(rd, 32'h0, "no flag on roll-over");
            check({31'h0, irq}, 32'h0, "no interrupt");
        end
        $display("test clock-out done");
        wr(`T2CC_OFF_CTRL, 32'h0);
        for (int m = 0; m < 3; m++)
        begin
            wr(`T2CC_OFF_MODE, m == 0 ? 32'h18 : m == 1 ? 32'h10 : 32'h0);
            repeat (2) @(posedge clk);
            check({31'h0, sharedPinOe}, {31'h0, m < 2}, "pin drive");
            if (m < 2)
                check({31'h0, sharedPinOut}, {31'h0, m == 0}, "pin value");
        end
        $display("test plain pin done");
        final_report();
    end
endmodule

bind t2cc_timer t2cc_timer_checker u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sharedPinOe(sharedPinOe), .serialClockPulse(serialClockPulse), .irq(irq));
`default_nettype wire
